// File: design/idq_consts.svh
// Offsets, field positions, reset values and timing counts of the card glue.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef IDQ_CONSTS_SVH
`define IDQ_CONSTS_SVH
// Register indices, byte address is four times the index
`define IDQ_IX_PACER_LO 5'h01
`define IDQ_IX_PACER_HI 5'h02
`define IDQ_IX_TMR_CTL 5'h03
`define IDQ_IX_AD_LO 5'h04
`define IDQ_IX_AD_HI 5'h05
`define IDQ_IX_DI_LO 5'h06
`define IDQ_IX_DI_HI 5'h07
`define IDQ_IX_CLR_IRQ 5'h08
`define IDQ_IX_MUX 5'h0A
`define IDQ_IX_MODE 5'h0B
`define IDQ_IX_SWTRIG 5'h0C
`define IDQ_IX_DO_LO 5'h0D
`define IDQ_IX_DO_HI 5'h0E
`define IDQ_IX_INT_STAT 5'h10
`define IDQ_IX_INT_MASK 5'h11
// Field positions
`define IDQ_AD_READY_BIT 4
`define IDQ_MODE_PACER_BIT 0
`define IDQ_MODE_IEN_BIT 1
`define IDQ_MODE_LVL_LSB 2
`define IDQ_ST_DONE_BIT 0
`define IDQ_ST_MISS_BIT 1
// Reset values and interrupt level limits
`define IDQ_BASE_DEFAULT 6'h22
`define IDQ_LVL_MIN 3'h2
`define IDQ_LVL_MAX 3'h7
`define IDQ_PACER_RST 32'h0000_0002
// Timing
`define IDQ_CLK_NS 40
`define IDQ_CONV_NS 8000
`define IDQ_SYS_MHZ 25
`define IDQ_PACER_MHZ 2
`endif

// File: design/idq_pkg.sv
// Types shared by the card glue logic.
// Assumes the constants header sits beside it.
package idq_pkg;
	// Converter sequencer states, one bit apart
	typedef enum logic [0:0] {
		CV_IDLE = 1'b0,
		CV_BUSY = 1'b1
	} idq_conv_t;
endpackage

// File: design/idq_top.sv
// Host-side glue of a data acquisition card: port window decode, pacer,
// converter sequencing, digital ports, interrupt levels and a Wishbone slave.
// Assumes ISA pins, switches, jumper and converter data are asynchronous.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "idq_consts.svh"
`default_nettype none
// Contract
// - Claim exactly sixteen ports from base
// - Match A9..A4 to switches, OFF is one
// - Delivered base window is 220 to 22F
// - Channels one and two chain 32-bit pacer
// - Pacer counts a 2 MHz reference
// - Conversion starts by software or pacer
// - Interrupt on one software chosen level 2-7
// - Control register enable gates the ISA interrupt levels; the software interrupt uses the mask
// - 16-bit output latch, 16-bit input read
// - 12-bit result, pending held 8 us
// - 16 single-ended or 8 differential channels
// - Pending flag clears when conversion completes
// - A write to 8 with byte lane 0 set clears done, unless a conversion ends in the same cycle
module idq_top import idq_pkg::*; #(
	parameter int CONV_NS = `IDQ_CONV_NS // Conversion time in ns
) (
	input wire logic clk_sys, // System clock, 25 MHz
	input wire logic reset, // Synchronous reset, high
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [6:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lanes
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic irq_o, // Level interrupt to software
	input wire logic [9:0] isa_addr, // ISA address pins
	input wire logic isa_aen, // Address enable, high in DMA
	input wire logic isa_ior_n, // I/O read strobe
	input wire logic isa_iow_n, // I/O write strobe
	input wire logic [5:0] base_address_switch, // High means OFF
	input wire logic input_config_jumper, // High selects differential
	output logic isa_sel_q, // Card claims the current cycle
	output logic [3:0] isa_port_q, // Port offset inside window
	output logic [7:2] isa_irq_q, // ISA interrupt request lines
	input wire logic [15:0] di_pins, // Digital input pins
	output logic [15:0] do_port_q, // Digital output latch
	input wire logic [11:0] adc_data, // Converter result pins
	output logic adc_start_q, // Start pulse to converter
	output logic [3:0] adc_chan_q // Analog channel select
);
	localparam int CONV_CYC = (CONV_NS + `IDQ_CLK_NS - 1) / `IDQ_CLK_NS; // Round up

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [35:0] sy1_q, sy2_q; // Two flops on every pin
	logic [11:0] ad1_q, ad2_q; // Converter data pins
	always_ff @(posedge clk_sys) begin
		sy1_q <= {di_pins, isa_addr, isa_aen, isa_ior_n, isa_iow_n, base_address_switch,
			input_config_jumper};
		sy2_q <= sy1_q;
		ad1_q <= adc_data;
		ad2_q <= ad1_q;
	end
	logic [15:0] di_s; // Synchronised digital inputs
	logic [9:0] addr_s; // Synchronised address
	logic aen_s, ior_s, iow_s, diff_s; // Synchronised controls
	logic [5:0] sw_s; // Synchronised switches
	assign {di_s, addr_s, aen_s, ior_s, iow_s, sw_s, diff_s} = sy2_q;

	// ****************************************
	// State registers
	// ****************************************
	logic [5:0] base_q, base_d; // Switch base, bits A9..A4
	logic sel_d; // Window hit
	logic [3:0] port_d; // Offset inside window
	logic [4:0] acc_q, acc_d; // Fractional 2 MHz divider
	logic tick_q, tick_d; // 2 MHz enable pulse
	logic [15:0] div_lo_q, div_lo_d, div_hi_q, div_hi_d; // Chained divisor halves
	logic [31:0] cnt_q, cnt_d; // Pacer down counter
	logic run_q, run_d; // Pacer running
	logic pace_q, pace_d; // Pacer trigger pulse
	idq_conv_t cv_q, cv_d; // Converter sequencer
	logic [7:0] cyc_q, cyc_d; // Conversion cycle count
	logic ready_n_q, ready_n_d; // Pending, high while result not valid
	logic [11:0] res_q, res_d; // Conversion result
	logic start_d; // Converter start
	logic [3:0] chan_d; // Channel select
	logic [4:0] mode_q, mode_d; // Pacer source, enable, level
	logic done_q, done_d; // Card done status
	logic [15:0] do_d; // Output latch
	logic [1:0] st_q, st_d, msk_q, msk_d; // Sticky status and mask
	logic [7:2] irql_d; // ISA request lines
	logic irq_d; // Software interrupt
	logic ack_d; // Bus acknowledge
	logic [31:0] rd_d; // Bus read data

	// Bus decode terms
	logic bus_req, bus_wr; // Request in flight, write strobe
	logic [4:0] ix; // Register index
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i;
	assign ix = wb_adr_i[6:2];

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic trig; // Conversion request this cycle
		logic fin; // Conversion ends this cycle
		logic [2:0] lvl; // Selected interrupt level
		trig = 1'b0;
		fin = 1'b0;
		lvl = mode_q[`IDQ_MODE_LVL_LSB +: 3];
		base_d = sw_s;
		sel_d = (addr_s[9:4] == base_q) && !aen_s && (!ior_s || !iow_s);
		port_d = addr_s[3:0];
		acc_d = acc_q + 5'(`IDQ_PACER_MHZ);
		tick_d = 1'b0;
		if (acc_d >= 5'(`IDQ_SYS_MHZ)) begin
			acc_d = acc_d - 5'(`IDQ_SYS_MHZ);
			tick_d = 1'b1;
		end
		div_lo_d = div_lo_q;
		div_hi_d = div_hi_q;
		run_d = run_q;
		cnt_d = cnt_q;
		pace_d = 1'b0;
		if (run_q && tick_q) begin
			if (cnt_q <= 32'h0000_0001) begin
				cnt_d = {div_hi_q, div_lo_q};
				pace_d = 1'b1;
			end else begin
				cnt_d = cnt_q - 32'h0000_0001;
			end
		end
		mode_d = mode_q;
		chan_d = adc_chan_q;
		do_d = do_port_q;
		msk_d = msk_q;
		st_d = st_q;
		done_d = done_q;
		if (bus_wr && wb_sel_i[0]) begin
			unique case (ix)
				`IDQ_IX_PACER_LO: div_lo_d = wb_dat_i[15:0];
				`IDQ_IX_PACER_HI: div_hi_d = wb_dat_i[15:0];
				`IDQ_IX_TMR_CTL: begin
					run_d = wb_dat_i[0];
					cnt_d = {div_hi_q, div_lo_q};
				end
				`IDQ_IX_MUX: chan_d = wb_dat_i[3:0];
				`IDQ_IX_MODE: mode_d = wb_dat_i[4:0];
				`IDQ_IX_SWTRIG: trig = !mode_q[`IDQ_MODE_PACER_BIT];
				`IDQ_IX_CLR_IRQ: done_d = 1'b0;
				`IDQ_IX_DO_LO: do_d[7:0] = wb_dat_i[7:0];
				`IDQ_IX_DO_HI: do_d[15:8] = wb_dat_i[7:0];
				`IDQ_IX_INT_STAT: st_d = st_q & ~wb_dat_i[1:0];
				`IDQ_IX_INT_MASK: msk_d = wb_dat_i[1:0];
				default: ;
			endcase
		end
		if (diff_s) begin
			chan_d[3] = 1'b0;
		end
		if (mode_q[`IDQ_MODE_PACER_BIT] && pace_q) begin
			trig = 1'b1;
		end
		cv_d = cv_q;
		cyc_d = cyc_q;
		ready_n_d = ready_n_q;
		res_d = res_q;
		start_d = 1'b0;
		unique case (cv_q)
			CV_IDLE: begin
				if (trig) begin
					cv_d = CV_BUSY;
					cyc_d = 8'(CONV_CYC - 1);
					ready_n_d = 1'b1;
					start_d = 1'b1;
				end
			end
			CV_BUSY: begin
				if (trig) begin
					st_d[`IDQ_ST_MISS_BIT] = 1'b1;
				end
				if (cyc_q == 8'h00) begin
					cv_d = CV_IDLE;
					fin = 1'b1;
					res_d = ad2_q;
				end else begin
					cyc_d = cyc_q - 8'h01;
				end
			end
		endcase
		if (fin) begin
			ready_n_d = 1'b0;
			done_d = 1'b1;
			st_d[`IDQ_ST_DONE_BIT] = 1'b1;
		end
		irql_d = '0;
		if (done_q && mode_q[`IDQ_MODE_IEN_BIT] && lvl >= `IDQ_LVL_MIN) begin
			irql_d[lvl] = 1'b1;
		end
		irq_d = |(st_q & msk_q);
		ack_d = bus_req;
		rd_d = '0;
		if (bus_req && !wb_we_i) begin
			unique case (ix)
				`IDQ_IX_PACER_LO: rd_d[15:0] = cnt_q[15:0];
				`IDQ_IX_PACER_HI: rd_d[15:0] = cnt_q[31:16];
				`IDQ_IX_AD_LO: rd_d[7:0] = res_q[7:0];
				`IDQ_IX_AD_HI: rd_d[7:0] = {3'b000, ready_n_q, res_q[11:8]};
				`IDQ_IX_DI_LO: rd_d[7:0] = di_s[7:0];
				`IDQ_IX_DI_HI: rd_d[7:0] = di_s[15:8];
				`IDQ_IX_MODE: rd_d[4:0] = mode_q;
				`IDQ_IX_INT_STAT: rd_d[1:0] = st_q;
				`IDQ_IX_INT_MASK: rd_d[1:0] = msk_q;
				default: rd_d = '0;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			base_q <= `IDQ_BASE_DEFAULT;
			isa_sel_q <= 1'b0;
			isa_port_q <= '0;
			acc_q <= '0;
			tick_q <= 1'b0;
			div_lo_q <= 16'(`IDQ_PACER_RST);
			div_hi_q <= '0;
			cnt_q <= `IDQ_PACER_RST;
			run_q <= 1'b0;
			pace_q <= 1'b0;
			cv_q <= CV_IDLE;
			cyc_q <= '0;
			ready_n_q <= 1'b1;
			res_q <= '0;
			adc_start_q <= 1'b0;
			adc_chan_q <= '0;
			mode_q <= '0;
			done_q <= 1'b0;
			do_port_q <= '0;
			st_q <= '0;
			msk_q <= '0;
			isa_irq_q <= '0;
			irq_o <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			base_q <= base_d;
			isa_sel_q <= sel_d;
			isa_port_q <= port_d;
			acc_q <= acc_d;
			tick_q <= tick_d;
			div_lo_q <= div_lo_d;
			div_hi_q <= div_hi_d;
			cnt_q <= cnt_d;
			run_q <= run_d;
			pace_q <= pace_d;
			cv_q <= cv_d;
			cyc_q <= cyc_d;
			ready_n_q <= ready_n_d;
			res_q <= res_d;
			adc_start_q <= start_d;
			adc_chan_q <= chan_d;
			mode_q <= mode_d;
			done_q <= done_d;
			do_port_q <= do_d;
			st_q <= st_d;
			msk_q <= msk_d;
			isa_irq_q <= irql_d;
			irq_o <= irq_d;
			wb_ack_o <= ack_d;
			wb_dat_o <= rd_d;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	logic [8:0] bz_q; // Cycles spent pending
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bz_q <= '0;
		end else if (adc_start_q) begin
			// Start cycle is already the first pending cycle
			bz_q <= 9'h001;
		end else if (ready_n_q && bz_q != 9'h1FF) begin
			bz_q <= bz_q + 9'h001;
		end
	end
	property p_window;
		@(posedge clk_sys) disable iff (reset)
		isa_sel_q |-> $past(addr_s[9:4]) == $past(base_q);
	endproperty
	a_window: assert property (p_window) else $error("claim outside window");
	property p_aen;
		@(posedge clk_sys) disable iff (reset)
		$past(aen_s) |-> !isa_sel_q;
	endproperty
	a_aen: assert property (p_aen) else $error("claim during DMA cycle");
	property p_irq_gate;
		@(posedge clk_sys) disable iff (reset)
		(isa_irq_q != 6'h00) |-> $past(mode_q[`IDQ_MODE_IEN_BIT]) && $past(done_q);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt");
	property p_one_level;
		@(posedge clk_sys) disable iff (reset)
		$onehot0(isa_irq_q);
	endproperty
	a_one_level: assert property (p_one_level) else $error("several levels");
	sequence s_conv_start;
		adc_start_q && ready_n_q;
	endsequence
	property p_pending;
		@(posedge clk_sys) disable iff (reset)
		s_conv_start |=> ready_n_q [*8];
	endproperty
	a_pending: assert property (p_pending) else $error("pending dropped early");
	property p_conv_len;
		@(posedge clk_sys) disable iff (reset)
		$fell(ready_n_q) && $past(cv_q) == CV_BUSY |-> bz_q == 9'(CONV_CYC);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("wrong conversion length");
	property p_clear;
		@(posedge clk_sys) disable iff (reset)
		bus_wr && wb_sel_i[0] && ix == `IDQ_IX_CLR_IRQ && !(cv_q == CV_BUSY && cyc_q == 8'h00)
			|=> !done_q ##1 isa_irq_q == 6'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("done not cleared");
	property p_chan;
		@(posedge clk_sys) disable iff (reset)
		$past(diff_s) |-> !adc_chan_q[3];
	endproperty
	a_chan: assert property (p_chan) else $error("channel out of range");
	property p_pacer_src;
		@(posedge clk_sys) disable iff (reset)
		pace_q && mode_q[`IDQ_MODE_PACER_BIT] && cv_q == CV_IDLE |=> adc_start_q;
	endproperty
	a_pacer_src: assert property (p_pacer_src) else $error("pacer did not start");
	property p_ack;
		@(posedge clk_sys) disable iff (reset)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack longer than a cycle");
endmodule // idq_top
`default_nettype wire

// File: sim/idq_isa_host.sv
// ISA host model: drives port cycles onto the card pins.
// Assumes the bench calls io_start and io_end from one process.
`timescale 1ns/1ps
`default_nettype none
module idq_isa_host (
	input wire logic clk_sys, // System clock
	output logic [9:0] isa_addr, // Address pins
	output logic isa_aen, // High in DMA cycles
	output logic isa_ior_n, // Read strobe
	output logic isa_iow_n // Write strobe
);
	// Idle bus: strobes high, no DMA
	initial begin
		isa_addr = 10'h155;
		isa_aen = 1'b0;
		isa_ior_n = 1'b1;
		isa_iow_n = 1'b1;
	end
	task automatic io_start(input logic [9:0] a, input logic rd, input logic dma);
		@(posedge clk_sys);
		isa_addr <= a;
		isa_aen <= dma;
		isa_ior_n <= !rd;
		isa_iow_n <= rd;
	endtask
	// Released address shows its inverse so stale bits never match
	task automatic io_end;
		@(posedge clk_sys);
		isa_ior_n <= 1'b1;
		isa_iow_n <= 1'b1;
		isa_aen <= 1'b0;
		isa_addr <= ~isa_addr;
	endtask
endmodule // idq_isa_host
`default_nettype wire

// File: sim/idq_top_test.sv
// Bench for the card glue: bus, port decode, conversions, pacer, ports.
// Assumes the design files and the ISA host model are compiled first.
`timescale 1ns/1ps
`include "idq_consts.svh"
`default_nettype none
module idq_top_test;
	logic clk_sys = 1'b0; // 25 MHz clock
	logic reset = 1'b1; // Held 10 cycles
	logic wb_cyc = 1'b0; // Bus request
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [6:0] wb_adr = 7'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0000_0000;
	logic [31:0] wb_rdat;
	logic wb_ack, irq, isa_sel, isa_aen, isa_ior_n, isa_iow_n, adc_start;
	wire logic [9:0] isa_addr; // From host model
	logic [5:0] sw = 6'h22; // Delivered setting
	logic jmp = 1'b0; // Single-ended
	logic [3:0] isa_port, adc_chan, ch;
	logic [7:2] isa_irq;
	logic [15:0] di = 16'h0000;
	logic [15:0] do_q;
	logic [11:0] ad = 12'h000;
	logic [11:0] ad_prev = 12'h000; // Result of the previous conversion
	logic [31:0] q, v, c0;
	logic [2:0] lvl;
	logic en;
	logic [9:0] corner [0:4] = '{10'h220, 10'h22F, 10'h21F, 10'h230, 10'h225};
	int n_fail = 0;
	int checks = 0;
	int seed = 32'h0026;
	int n_start = 0; // Start pulses seen
	int k;
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (adc_start === 1'b1) n_start <= n_start + 1;
	idq_isa_host host_u (.clk_sys(clk_sys), .isa_addr(isa_addr), .isa_aen(isa_aen),
		.isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n));
	idq_top dut_u (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq), .isa_addr(isa_addr),
		.isa_aen(isa_aen), .isa_ior_n(isa_ior_n), .isa_iow_n(isa_iow_n),
		.base_address_switch(sw), .input_config_jumper(jmp), .isa_sel_q(isa_sel),
		.isa_port_q(isa_port), .isa_irq_q(isa_irq), .di_pins(di), .do_port_q(do_q),
		.adc_data(ad), .adc_start_q(adc_start), .adc_chan_q(adc_chan));
	task automatic conclude;
		if (n_fail == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One classic cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [4:0] ix, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {ix, 2'b00};
		wb_sel <= s;
		wb_wdat <= d;
		do @(posedge clk_sys); while (wb_ack !== 1'b1);
		r = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] ix, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, ix, 4'hF, d, r);
	endtask
	task automatic rd_chk(input logic [4:0] ix, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, ix, 4'hF, 32'h0000_0000, r);
		cmp(r, e);
	endtask
	// Hold a port cycle long enough to pass the synchronisers
	task automatic isa_chk(input logic [9:0] a, input logic dma);
		host_u.io_start(a, seed[0], dma);
		repeat (4) @(posedge clk_sys);
		#1;
		cmp(isa_sel, a[9:4] == sw && !dma);
		if (isa_sel === 1'b1) cmp(isa_port, a[3:0]);
		host_u.io_end();
	endtask
	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		rd_chk(`IDQ_IX_AD_HI, 32'h0000_0010);
		rd_chk(5'h1F, 32'h0000_0000);
		// Corners first, then random switch settings
		for (k = 0; k < 12; k++) begin
			if (k >= 5) sw <= 6'($random(seed));
			repeat (5) @(posedge clk_sys);
			v = $random(seed);
			isa_chk(k < 5 ? corner[k] : (v[10] ? {sw, v[3:0]} : v[9:0]), k == 4);
		end
		for (k = 0; k < 3; k++) begin
			v = $random(seed);
			wr(`IDQ_IX_DO_LO, {24'h0, v[7:0]});
			wr(`IDQ_IX_DO_HI, {24'h0, v[15:8]});
			wb(1'b1, `IDQ_IX_DO_LO, 4'hE, ~v, q);
			di <= v[31:16];
			repeat (4) @(posedge clk_sys);
			cmp(do_q, v[15:0]);
			rd_chk(`IDQ_IX_DI_LO, v[23:16]);
			rd_chk(`IDQ_IX_DI_HI, v[31:24]);
		end
		// Software conversions on every level; last pass has interrupts off
		for (k = 2; k <= 8; k++) begin
			en = (k < 8);
			lvl = en ? 3'(k) : 3'h3;
			ad <= 12'($random(seed));
			ch = 4'($random(seed));
			jmp <= k[0];
			wr(`IDQ_IX_INT_MASK, {31'h0, en});
			wr(`IDQ_IX_MUX, {28'h0, ch});
			wr(`IDQ_IX_MODE, {27'h0, lvl, en, 1'b0});
			rd_chk(`IDQ_IX_MODE, {27'h0, lvl, en, 1'b0});
			v = n_start;
			wr(`IDQ_IX_SWTRIG, 32'h0000_0000);
			if (k == 2) wr(`IDQ_IX_SWTRIG, 32'h0000_0000);
			repeat (180) @(posedge clk_sys);
			rd_chk(`IDQ_IX_AD_HI, {24'h0, 4'h1, ad_prev[11:8]});
			repeat (20) @(posedge clk_sys);
			rd_chk(`IDQ_IX_AD_LO, {24'h0, ad[7:0]});
			rd_chk(`IDQ_IX_AD_HI, {28'h0, ad[11:8]});
			cmp(n_start - v, 1);
			cmp(adc_chan, k[0] ? {1'b0, ch[2:0]} : ch);
			cmp({isa_irq, 2'b00}, en ? 32'(8'h1 << lvl) : 32'h0);
			cmp(irq, en);
			rd_chk(`IDQ_IX_INT_STAT, {30'h0, k == 2, 1'b1});
			wr(`IDQ_IX_INT_MASK, 32'h0000_0001);
			repeat (3) @(posedge clk_sys);
			cmp(irq, 1'b1);
			wr(`IDQ_IX_CLR_IRQ, $random(seed));
			wr(`IDQ_IX_INT_STAT, 32'h0000_0003);
			repeat (3) @(posedge clk_sys);
			cmp(isa_irq, 6'h00);
			cmp(irq, 1'b0);
			ad_prev = ad;
		end
		// Pacer source, divisor 40 ticks of the 2 MHz reference
		wr(`IDQ_IX_MODE, 32'h0000_0001);
		wr(`IDQ_IX_PACER_LO, 32'd40);
		wr(`IDQ_IX_PACER_HI, 32'h0000_0000);
		v = n_start;
		wr(`IDQ_IX_TMR_CTL, 32'h0000_0001);
		wb(1'b0, `IDQ_IX_PACER_LO, 4'hF, 32'h0, c0);
		repeat (250) @(posedge clk_sys);
		wb(1'b0, `IDQ_IX_PACER_LO, 4'hF, 32'h0, q);
		cmp((c0[15:0] - q[15:0]) inside {[16'd19:16'd21]}, 1'b1);
		repeat (850) @(posedge clk_sys);
		cmp(n_start - v, 2);
		wr(`IDQ_IX_TMR_CTL, 32'h0000_0000);
		conclude();
	end
endmodule // idq_top_test
`default_nettype wire
